// ### sleep_host_model.sv
// memory controller model for the sleep pin
`timescale 1ns/1ns
module sleep_host_model (
  input  wire logic clock_in,
  input  wire logic recovering_in,
  output logic      request_out,
  output logic      driven_out,
  output logic      select_out,
  output logic      write_out
);
  logic level_r = 1'h0;
  logic wr_r    = 1'h0;
  initial driven_out = 1'h1;
  initial select_out = 1'h0;
  // a released pin shows high here; only the device's pull-down keeps it low
  assign request_out = driven_out ? level_r : 1'h1;
  assign write_out   = wr_r & ~recovering_in;
  task automatic acc(input logic sel, input logic wr);
    @(negedge clock_in);
    select_out = sel;
    wr_r       = wr;
  endtask : acc
  task automatic pin(input logic lvl, input logic drv);
    if (lvl) acc(1'h0, 1'h0);
    @(negedge clock_in);
    level_r    = lvl;
    driven_out = drv;
  endtask : pin
endmodule : sleep_host_model

// ### sleep_pkg.sv
// constants for the sram sleep mode controller
package sleep_pkg;
  // clock rate and recovery figure
  localparam int unsigned CLOCK_PERIOD_NS       = 100;
  localparam int unsigned WAKE_RECOVERY_TIME_NS = 20;
  // least time rounds up, never under one cycle
  localparam int unsigned WAKE_RECOVERY_RAW =
    (WAKE_RECOVERY_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned WAKE_RECOVERY_CYCLES  = (WAKE_RECOVERY_RAW < 1) ? 1 : WAKE_RECOVERY_RAW;
  // sleep entry delay in cycles
  localparam int unsigned SLEEP_ENTRY_CYCLES    = 2;
  localparam int unsigned COUNT_W               = 4;
  localparam logic [3:0]  COUNT_RESET           = 4'h0;
  // power states
  typedef enum logic [1:0] {
    PWR_AWAKE,
    PWR_ENTERING,
    PWR_ASLEEP,
    PWR_RECOVERING
  } power_state_t;
endpackage : sleep_pkg

// ### sleep_sync.sv
// two flip-flop synchroniser for the sleep request pin
`timescale 1ns/1ns
module sleep_sync (
  input  wire logic clock_in,
  input  wire logic reset_n_in,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_r;
  logic sync_r;
  logic meta_nxt;
  logic sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule : sleep_sync

// ### sram_sleep_mode_control.sv
// sleep entry and wake recovery sequencer for a synchronous burst sram
// Notes on behaviour
// - request high makes the device sleep two clock cycles later; here four cycles after the pin, two of them in the synchroniser.
// - all internal state and array contents are kept while asleep.
// - request is held low normally; an undriven request reads low.
// - after request falls, normal operation waits out the recovery time.
// - asleep, the device acts deselected and draws standby current only.
// - asleep, all inputs but the request are ignored; outputs float.
// - request is active high, asynchronous; sleep lasts while it stays high.
`timescale 1ns/1ns
module sram_sleep_mode_control #(
  parameter int unsigned ENTRY_CYCLES    = sleep_pkg::SLEEP_ENTRY_CYCLES,
  parameter int unsigned RECOVERY_CYCLES = sleep_pkg::WAKE_RECOVERY_CYCLES
) (
  input  wire logic clock_in,
  input  wire logic reset_n_in,
  input  wire logic sleep_request_in,
  input  wire logic sleep_request_driven_in,
  input  wire logic access_select_in,
  input  wire logic access_write_in,
  output logic      sleep_active_out,
  output logic      standby_current_out,
  output logic      inputs_enable_out,
  output logic      output_enable_n_out,
  output logic      state_hold_out,
  output logic      recovering_out,
  output logic      access_select_out,
  output logic      access_write_out,
  output logic      ready_out
);
  // ==========================================================
  // request conditioning
  logic level_sync;
  logic driven_sync;
  logic req_sync;

  // pin level and drive flag each pass their own two flops
  sleep_sync u_sync_level (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .async_in   (sleep_request_in),
    .sync_out   (level_sync)
  );

  sleep_sync u_sync_driven (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .async_in   (sleep_request_driven_in),
    .sync_out   (driven_sync)
  );

  // undriven pin reads low, as the pull-down leaves it
  assign req_sync = level_sync & driven_sync;

  // ==========================================================
  // power state machine
  sleep_pkg::power_state_t state_r;
  sleep_pkg::power_state_t state_nxt;
  logic [sleep_pkg::COUNT_W-1:0] count_r;
  logic [sleep_pkg::COUNT_W-1:0] count_nxt;
  logic                          sel_r;
  logic                          sel_nxt;
  logic                          wr_r;
  logic                          wr_nxt;

  // last count values of the entry and recovery waits
  localparam logic [sleep_pkg::COUNT_W-1:0] ENTRY_LAST = sleep_pkg::COUNT_W'(ENTRY_CYCLES - 1);
  localparam logic [sleep_pkg::COUNT_W-1:0] RECOV_LAST = sleep_pkg::COUNT_W'(RECOVERY_CYCLES - 1);

  // ==========================================================
  // state decoding
  // asleep: deselected, outputs floated
  function automatic logic is_asleep(input sleep_pkg::power_state_t s);
    return (s == sleep_pkg::PWR_ASLEEP);
  endfunction : is_asleep

  // waking: reads only
  function automatic logic is_recovering(input sleep_pkg::power_state_t s);
    return (s == sleep_pkg::PWR_RECOVERING);
  endfunction : is_recovering

  // normal operation, entry included
  function automatic logic is_ready(input sleep_pkg::power_state_t s);
    return (s == sleep_pkg::PWR_AWAKE) || (s == sleep_pkg::PWR_ENTERING);
  endfunction : is_ready

  // ==========================================================
  // next state

  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      sleep_pkg::PWR_AWAKE: begin
        if (req_sync) begin
          state_nxt = (ENTRY_CYCLES <= 1) ? sleep_pkg::PWR_ASLEEP : sleep_pkg::PWR_ENTERING;
          count_nxt = sleep_pkg::COUNT_RESET;
        end
      end
      sleep_pkg::PWR_ENTERING: begin
        // request gone before the count ends: abort entry
        if (!req_sync) begin
          state_nxt = sleep_pkg::PWR_AWAKE;
          count_nxt = sleep_pkg::COUNT_RESET;
        end else if (count_r + 1'b1 >= ENTRY_LAST) begin
          state_nxt = sleep_pkg::PWR_ASLEEP;
          count_nxt = sleep_pkg::COUNT_RESET;
        end else begin
          count_nxt = count_r + 1'b1;
        end
      end
      sleep_pkg::PWR_ASLEEP: begin
        if (!req_sync) begin
          state_nxt = sleep_pkg::PWR_RECOVERING;
          count_nxt = sleep_pkg::COUNT_RESET;
        end
      end
      sleep_pkg::PWR_RECOVERING: begin
        // request back high: straight back to sleep
        if (req_sync) begin
          state_nxt = sleep_pkg::PWR_ASLEEP;
          count_nxt = sleep_pkg::COUNT_RESET;
        end else if (count_r >= RECOV_LAST) begin
          state_nxt = sleep_pkg::PWR_AWAKE;
          count_nxt = sleep_pkg::COUNT_RESET;
        end else begin
          count_nxt = count_r + 1'b1;
        end
      end
      default: begin
        state_nxt = sleep_pkg::PWR_AWAKE;
        count_nxt = sleep_pkg::COUNT_RESET;
      end
    endcase
  end

  // state and count registers
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= sleep_pkg::PWR_AWAKE;
      count_r <= sleep_pkg::COUNT_RESET;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  // ==========================================================
  // access gating
  // registered from the next state so gating turns with the state edge
  always_comb begin
    sel_nxt = 1'b0;
    wr_nxt  = 1'b0;
    case (state_nxt)
      sleep_pkg::PWR_AWAKE,
      sleep_pkg::PWR_ENTERING: begin
        sel_nxt = access_select_in;
        wr_nxt  = access_select_in & access_write_in;
      end
      sleep_pkg::PWR_RECOVERING: begin
        sel_nxt = access_select_in & ~access_write_in;
        wr_nxt  = 1'b0;
      end
      default: begin
        sel_nxt = 1'b0;
        wr_nxt  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sel_r <= 1'b0;
      wr_r  <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
      wr_r  <= wr_nxt;
    end
  end

  // ==========================================================
  // status outputs
  logic sleep_r;
  logic sleep_nxt;
  logic recov_r;
  logic recov_nxt;
  logic ready_r;
  logic ready_nxt;

  // decoded from the next state so flags change with the state itself
  always_comb begin
    sleep_nxt = is_asleep(state_nxt);
    recov_nxt = is_recovering(state_nxt);
    ready_nxt = is_ready(state_nxt);
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sleep_r <= 1'b0;
      recov_r <= 1'b0;
      ready_r <= 1'b1;
    end else begin
      sleep_r <= sleep_nxt;
      recov_r <= recov_nxt;
      ready_r <= ready_nxt;
    end
  end

  // every sleep flag follows one register
  assign sleep_active_out    = sleep_r;
  assign standby_current_out = sleep_r;
  assign inputs_enable_out   = ~sleep_r;
  assign output_enable_n_out = sleep_r;
  assign state_hold_out      = sleep_r;
  assign recovering_out      = recov_r;
  assign ready_out           = ready_r;
  assign access_select_out   = sel_r;
  assign access_write_out    = wr_r;
endmodule : sram_sleep_mode_control

// ### sram_sleep_mode_control_bench.sv
// testbench for the sram sleep controller
`timescale 1ns/1ns
module sram_sleep_mode_control_bench;
  logic clock_in = 1'h0;
  logic reset_n_in = 1'h0;
  wire logic sleep_request_in, sleep_request_driven_in, access_select_in, access_write_in, sleep_active_out;
  wire logic standby_current_out, inputs_enable_out, output_enable_n_out, state_hold_out, recovering_out;
  wire logic access_select_out, access_write_out, ready_out;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [7:0] n;
  sram_sleep_mode_control dut (
    .clock_in                (clock_in),
    .reset_n_in              (reset_n_in),
    .sleep_request_in        (sleep_request_in),
    .sleep_request_driven_in (sleep_request_driven_in),
    .access_select_in        (access_select_in),
    .access_write_in         (access_write_in),
    .sleep_active_out        (sleep_active_out),
    .standby_current_out     (standby_current_out),
    .inputs_enable_out       (inputs_enable_out),
    .output_enable_n_out     (output_enable_n_out),
    .state_hold_out          (state_hold_out),
    .recovering_out          (recovering_out),
    .access_select_out       (access_select_out),
    .access_write_out        (access_write_out),
    .ready_out               (ready_out)
  );
  sleep_host_model host (.clock_in, .recovering_in(recovering_out), .request_out(sleep_request_in),
    .driven_out(sleep_request_driven_in), .select_out(access_select_in), .write_out(access_write_in));
  initial forever #50 clock_in = ~clock_in;
  // ==========
  // shared tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic wait_for(input logic on_ready);
    n = 8'h0;
    while ((on_ready ? ready_out : sleep_active_out) !== 1'h1) begin
      @(negedge clock_in);
      n++;
      if (n == 8'h14) begin n_mismatch++; give_verdict(); end
    end
  endtask : wait_for
  task automatic never_sleeps(input string what);
    n = 8'h0;
    repeat (8) begin @(negedge clock_in); n |= {7'h0, sleep_active_out}; end
    check(what, n, 8'h0);
  endtask : never_sleeps
  task automatic reset_values;
    check("reset", asel_pack(), 8'h03);
    check("reset recovering", {6'h0, recovering_out, sleep_active_out}, 8'h0);
  endtask : reset_values
  // ==========
  // scenarios
  task automatic sleep_cycle;
    host.pin(1'h1, 1'h1);
    wait_for(1'h0);
    check("entry", n, 8'(sleep_pkg::SLEEP_ENTRY_CYCLES + 2));
    host.acc(1'h1, 1'h1);
    repeat (3) @(negedge clock_in);
    check("asleep", {asel_pack()}, 8'h1c);
    host.pin(1'h0, 1'h1);
    repeat (3) @(negedge clock_in);
    check("recovering", {7'h0, recovering_out}, 8'h1);
    wait_for(1'h1);
    check("recovery", n, 8'(sleep_pkg::WAKE_RECOVERY_CYCLES));
    @(negedge clock_in);
    check("pass", {6'h0, access_select_out, access_write_out}, 8'h3);
  endtask : sleep_cycle
  function automatic logic [7:0] asel_pack;
    return {1'h0, access_select_out, access_write_out, output_enable_n_out, standby_current_out,
      state_hold_out, inputs_enable_out, ready_out};
  endfunction : asel_pack
  task automatic abort_entry;
    host.pin(1'h1, 1'h1);
    host.pin(1'h0, 1'h1);
    never_sleeps("abort");
  endtask : abort_entry
  task automatic undriven_pin;
    host.pin(1'h1, 1'h0);
    never_sleeps("undriven");
    host.pin(1'h0, 1'h1);
  endtask : undriven_pin
  initial begin
    repeat (12) @(negedge clock_in);
    reset_n_in = 1'h1;
    reset_values();
    sleep_cycle();
    abort_entry();
    undriven_pin();
    give_verdict();
  end
endmodule : sram_sleep_mode_control_bench

// ### sram_sleep_mode_control_sva.sv
// checker for the sram sleep controller
`timescale 1ns/1ns
module sram_sleep_mode_control_sva #(
  parameter int unsigned ENTRY_CYCLES    = 2,
  parameter int unsigned RECOVERY_CYCLES = 1
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic sleep_request_in,
  input wire logic sleep_request_driven_in,
  input wire logic access_select_in,
  input wire logic access_write_in,
  input wire logic sleep_active_out,
  input wire logic standby_current_out,
  input wire logic inputs_enable_out,
  input wire logic output_enable_n_out,
  input wire logic state_hold_out,
  input wire logic recovering_out,
  input wire logic access_select_out,
  input wire logic access_write_out,
  input wire logic ready_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  wire logic req = sleep_request_in & sleep_request_driven_in;
  // ==========
  // assertions
  AST_ENTRY: assert property (req [*5] |-> sleep_active_out) else $error("late sleep");
  AST_EARLY: assert property ($rose(sleep_active_out) |-> $past(req, 2) && $past(req, 3)) else $error("early");
  AST_STAY: assert property (req [*3] ##0 sleep_active_out |=> sleep_active_out) else $error("left sleep");
  AST_WAKE: assert property (!req [*5] |-> !sleep_active_out) else $error("still asleep");
  AST_UNDRIVEN: assert property (!sleep_request_driven_in [*5] |-> !sleep_active_out) else $error("pull");
  AST_RECOVER: assert property ($fell(sleep_active_out) |-> recovering_out && !ready_out ##1 !recovering_out)
    else $error("bad recovery");
  AST_ASLEEP: assert property (sleep_active_out |-> standby_current_out && state_hold_out
    && output_enable_n_out && !inputs_enable_out && !ready_out && !access_select_out && !access_write_out)
    else $error("awake");
  AST_NOWRITE: assert property (recovering_out |-> !access_write_out) else $error("write");
  AST_AWAKE: assert property (ready_out && $past(reset_n_in) |-> !output_enable_n_out
    && access_select_out == $past(access_select_in)
    && access_write_out == ($past(access_select_in) && $past(access_write_in)))
    else $error("no pass");
  COV_SLEEP: cover property ($rose(sleep_active_out));
  COV_RECOVER: cover property ($rose(recovering_out));
  COV_ABORT: cover property (!req ##1 req ##1 !req);
endmodule : sram_sleep_mode_control_sva
bind sram_sleep_mode_control sram_sleep_mode_control_sva #(
  .ENTRY_CYCLES            (ENTRY_CYCLES),
  .RECOVERY_CYCLES         (RECOVERY_CYCLES)
) chk (
  .clock_in                (clock_in),
  .reset_n_in              (reset_n_in),
  .sleep_request_in        (sleep_request_in),
  .sleep_request_driven_in (sleep_request_driven_in),
  .access_select_in        (access_select_in),
  .access_write_in         (access_write_in),
  .sleep_active_out        (sleep_active_out),
  .standby_current_out     (standby_current_out),
  .inputs_enable_out       (inputs_enable_out),
  .output_enable_n_out     (output_enable_n_out),
  .state_hold_out          (state_hold_out),
  .recovering_out          (recovering_out),
  .access_select_out       (access_select_out),
  .access_write_out        (access_write_out),
  .ready_out               (ready_out)
);
